// [poab_pkg.sv]
// package: constants and carrier types for the peak, trim and alert register bank
`default_nettype none
package poab_pkg;

    // ==========================================
    // register pages
    localparam logic [7:0] PAGE_PEAK0 = 8'h0c;
    localparam logic [7:0] PAGE_PEAK1 = 8'h0d;
    localparam logic [7:0] PAGE_TRIM0 = 8'h0e;
    localparam logic [7:0] PAGE_TRIM1 = 8'h0f;
    localparam logic [7:0] PAGE_ALERT = 8'h10;
    localparam logic [7:0] PAGE_ROUTE0 = 8'h11;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // ==========================================
    // register offsets within a page
    localparam logic [5:0] ADDR_PAGE_SEL = 6'h00;
    localparam logic [5:0] ADDR_BANK_A = 6'h10;
    localparam logic [5:0] ADDR_BANK_B = 6'h14;
    localparam logic [5:0] ADDR_BANK_C = 6'h20;
    localparam logic [5:0] ADDR_BANK_D = 6'h28;
    localparam logic [5:0] ADDR_UNI_TRIM = 6'h30;
    localparam logic [5:0] ADDR_BI_TRIM = 6'h34;
    localparam logic [5:0] ADDR_ROLLUP = 6'h10;
    localparam logic [5:0] ADDR_ALERT_INPUT = 6'h12;
    localparam logic [5:0] ADDR_ALERT_TEMP = 6'h14;
    localparam logic [5:0] ADDR_ALERT_CURRENT = 6'h15;
    localparam logic [5:0] ADDR_ALERT_SUPPLY = 6'h18;
    localparam logic [5:0] ADDR_ALERT_SHUNT = 6'h19;
    localparam logic [5:0] ADDR_ALERT_CLAMP = 6'h1a;

    // ==========================================
    // channel numbering shared by peaks, trims and the conversion port
    localparam int NUM_PEAK = 23;
    localparam int NUM_TRIM = 31;
    localparam int NUM_FLAG_GROUPS = 5;
    localparam int NUM_ROUTE_GROUPS = 6;
    localparam logic [4:0] CH_INPUT0 = 5'd0;
    localparam logic [4:0] CH_TEMP0 = 5'd4;
    localparam logic [4:0] CH_CURRENT0 = 5'd7;
    localparam logic [4:0] CH_SUPPLY0 = 5'd11;
    localparam logic [4:0] CH_BIMON0 = 5'd15;
    localparam logic [4:0] CH_SHUNT0 = 5'd19;
    localparam logic [4:0] CH_UNI_TRIM0 = 5'd23;
    localparam logic [4:0] CH_BI_TRIM0 = 5'd27;
    localparam logic [4:0] CH_NONE = 5'd31;

    // ==========================================
    // reset values and scaling
    localparam logic [15:0] PEAK_DEFAULT = 16'h0000;
    localparam logic [15:0] ROLLUP_RESET = 16'h0000;
    localparam logic [15:0] ROUTE_RESET = 16'h0000;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    // divide by 50 as multiply by round(65536/50) then drop 16 bits
    localparam logic [15:0] SHUNT_DIV50_MUL = 16'd1311;

    // ==========================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [4:0] chan;
        logic [15:0] code;
    } poab_conv_s;

    typedef struct packed {
        logic neg_supply_alarm;
        logic pos_supply_alarm;
        logic [3:0] clamp_active;
    } poab_loop_s;

    typedef logic [NUM_FLAG_GROUPS-1:0][15:0] poab_flags_t;
    typedef logic [NUM_TRIM-1:0][7:0] poab_trims_t;

endpackage
`default_nettype wire

// [poab_bank.sv]
// module: paged serial register bank with peak capture, offset trims and alert routing
`default_nettype none
module poab_bank
    import poab_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_din,
    output logic spi_dout,
    output logic spi_dout_oe,
    input wire poab_pkg::poab_conv_s conv,
    input wire poab_pkg::poab_flags_t alert_set,
    input wire poab_pkg::poab_loop_s loop_status,
    input wire logic copy_enable,
    output poab_pkg::poab_trims_t trim_out,
    output logic [3:0] bipolar_trim_update,
    output logic first_alert_output
);
    import poab_pkg::*;

    // ==========================================
    // register decoding
    // maps page and offset onto the shared channel numbering
    function automatic logic [4:0] chan_of(input logic [7:0] page, input logic [5:0] addr);
        logic odd;
        odd = page[0];
        chan_of = CH_NONE;
        if (!odd && addr >= ADDR_BANK_A && addr < ADDR_BANK_A + 6'd4)
        begin
            chan_of = CH_INPUT0 + 5'(addr - ADDR_BANK_A);
        end
        else if (!odd && addr >= ADDR_BANK_C && addr < ADDR_BANK_C + 6'd3)
        begin
            chan_of = CH_TEMP0 + 5'(addr - ADDR_BANK_C);
        end
        else if (!odd && addr >= ADDR_BANK_D && addr < ADDR_BANK_D + 6'd4)
        begin
            chan_of = CH_CURRENT0 + 5'(addr - ADDR_BANK_D);
        end
        else if (odd && addr >= ADDR_BANK_A && addr < ADDR_BANK_A + 6'd4)
        begin
            chan_of = CH_SUPPLY0 + 5'(addr - ADDR_BANK_A);
        end
        else if (odd && addr >= ADDR_BANK_B && addr < ADDR_BANK_B + 6'd4)
        begin
            chan_of = CH_BIMON0 + 5'(addr - ADDR_BANK_B);
        end
        else if (odd && addr >= ADDR_BANK_D && addr < ADDR_BANK_D + 6'd4)
        begin
            chan_of = CH_SHUNT0 + 5'(addr - ADDR_BANK_D);
        end
        else if (!odd && addr >= ADDR_UNI_TRIM && addr < ADDR_UNI_TRIM + 6'd8)
        begin
            chan_of = CH_UNI_TRIM0 + 5'(addr - ADDR_UNI_TRIM);
        end
    endfunction

    // alert group index for offsets on the alert and routing pages, 7 = none
    function automatic logic [2:0] group_of(input logic [5:0] addr);
        case (addr)
            ADDR_ALERT_INPUT: group_of = 3'd0;
            ADDR_ALERT_TEMP: group_of = 3'd1;
            ADDR_ALERT_CURRENT: group_of = 3'd2;
            ADDR_ALERT_SUPPLY: group_of = 3'd3;
            ADDR_ALERT_SHUNT: group_of = 3'd4;
            ADDR_ALERT_CLAMP: group_of = 3'd5;
            default: group_of = 3'd7;
        endcase
    endfunction

    // trim registers and the page select are one byte wide, the rest two
    function automatic logic is_byte_reg(input logic [7:0] page, input logic [5:0] addr);
        is_byte_reg = (addr == ADDR_PAGE_SEL) || page == PAGE_TRIM0 || page == PAGE_TRIM1;
    endfunction

    // ==========================================
    // pin synchronisers
    logic cs_s1_reg, cs_s2_reg;
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    logic din_s1_reg, din_s2_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end
        else
        begin
            cs_s1_reg <= spi_cs_n;
            cs_s2_reg <= cs_s1_reg;
            sclk_s1_reg <= spi_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            din_s1_reg <= spi_din;
            din_s2_reg <= din_s1_reg;
        end
    end

    logic sclk_rise, sclk_fall;
    assign sclk_rise = sclk_s2_reg && !sclk_s3_reg && !cs_s2_reg;
    assign sclk_fall = !sclk_s2_reg && sclk_s3_reg && !cs_s2_reg;

    // ==========================================
    // serial frame: address byte, then one or two data bytes
    logic addr_phase_reg, read_reg, wr_pulse_reg;
    logic [5:0] addr_reg;
    logic [15:0] rx_reg, wr_data_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] page_reg;
    logic [3:0] last_bit;
    logic [5:0] rx_addr;

    assign last_bit = is_byte_reg(page_reg, addr_reg) ? 4'd7 : 4'd15;
    assign rx_addr = {rx_reg[4:0], din_s2_reg};

    always_ff @(posedge clk)
    begin
        if (sys_rst || cs_s2_reg)
        begin
            addr_phase_reg <= 1'b1;
            bit_cnt_reg <= 4'd0;
            wr_pulse_reg <= 1'b0;
            if (sys_rst)
            begin
                read_reg <= 1'b0;
                addr_reg <= 6'h00;
                rx_reg <= 16'h0000;
                wr_data_reg <= 16'h0000;
            end
        end
        else
        begin
            wr_pulse_reg <= 1'b0;
            if (sclk_rise)
            begin
                rx_reg <= {rx_reg[14:0], din_s2_reg};
                if (addr_phase_reg)
                begin
                    if (bit_cnt_reg == 4'd7)
                    begin
                        addr_phase_reg <= 1'b0;
                        read_reg <= rx_reg[6];
                        addr_reg <= rx_addr;
                        bit_cnt_reg <= 4'd0;
                    end
                    else
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                    end
                end
                else if (bit_cnt_reg == last_bit)
                begin
                    // back to address phase: next register needs no new frame
                    addr_phase_reg <= 1'b1;
                    bit_cnt_reg <= 4'd0;
                    wr_pulse_reg <= !read_reg;
                    wr_data_reg <= {rx_reg[14:0], din_s2_reg};
                end
                else
                begin
                    bit_cnt_reg <= bit_cnt_reg + 4'd1;
                end
            end
        end
    end

    // page stays selected across frames
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            page_reg <= PAGE_RESET;
        end
        else if (wr_pulse_reg && addr_reg == ADDR_PAGE_SEL)
        begin
            page_reg <= wr_data_reg[7:0];
        end
    end

    // ==========================================
    // storage
    logic [15:0] peak_reg [NUM_PEAK];
    poab_flags_t flag_reg;
    logic [NUM_ROUTE_GROUPS-1:0][15:0] route_reg;

    logic wr_hit;
    logic [4:0] wr_chan;
    logic [2:0] wr_group;
    assign wr_hit = wr_pulse_reg && addr_reg != ADDR_PAGE_SEL;
    assign wr_chan = chan_of(page_reg, addr_reg);
    assign wr_group = group_of(addr_reg);

    // shunt results are referred to the divided-down input
    logic [31:0] shunt_product;
    logic [15:0] conv_value;
    assign shunt_product = 32'(conv.code) * 32'(SHUNT_DIV50_MUL);
    assign conv_value = (conv.chan >= CH_SHUNT0 && conv.chan < CH_UNI_TRIM0)
        ? shunt_product[31:16] : conv.code;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PEAK; gi++)
        begin : g_peak
            logic clear_hit;
            assign clear_hit = wr_hit && wr_chan == 5'(gi)
                && (page_reg == PAGE_PEAK0 || page_reg == PAGE_PEAK1);
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    peak_reg[gi] <= PEAK_DEFAULT;
                end
                else if (clear_hit)
                begin
                    peak_reg[gi] <= PEAK_DEFAULT;
                end
                else if (conv.valid && conv.chan == 5'(gi) && conv_value > peak_reg[gi])
                begin
                    peak_reg[gi] <= conv_value;
                end
            end
        end
    endgenerate

    // ==========================================
    // trims, with broadcast for the output trims
    logic trim_wr;
    logic [4:0] trim_idx;
    logic [3:0] bi_hit;
    assign trim_wr = wr_hit && (page_reg == PAGE_TRIM0 || page_reg == PAGE_TRIM1)
        && wr_chan != CH_NONE;
    assign trim_idx = wr_chan;

    generate
        for (gi = 0; gi < NUM_TRIM; gi++)
        begin : g_trim
            logic hit;
            if (gi >= CH_UNI_TRIM0)
            begin : g_out
                localparam logic [4:0] BASE = (gi >= CH_BI_TRIM0) ? CH_BI_TRIM0 : CH_UNI_TRIM0;
                assign hit = trim_wr && (trim_idx == 5'(gi)
                    || (copy_enable && trim_idx >= BASE && trim_idx < BASE + 5'd4));
                if (gi >= CH_BI_TRIM0)
                begin : g_bi
                    assign bi_hit[gi - CH_BI_TRIM0] = hit;
                end
            end
            else
            begin : g_mon
                assign hit = trim_wr && trim_idx == 5'(gi);
            end
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    trim_out[gi] <= TRIM_RESET;
                end
                else if (hit)
                begin
                    trim_out[gi] <= wr_data_reg[7:0];
                end
            end
        end
    endgenerate

    // one-cycle strobe telling the output stage to re-apply range or clamp limit
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bipolar_trim_update <= 4'h0;
        end
        else
        begin
            bipolar_trim_update <= bi_hit;
        end
    end

    // ==========================================
    // alert flags: rollup clear hits a whole byte, direct clear a single bit
    logic rollup_wr, flag_wr;
    assign rollup_wr = wr_hit && page_reg == PAGE_ALERT && addr_reg == ADDR_ROLLUP;
    assign flag_wr = wr_hit && page_reg == PAGE_ALERT && wr_group < 3'd5;

    generate
        for (gi = 0; gi < NUM_FLAG_GROUPS; gi++)
        begin : g_flag
            logic [15:0] clr;
            always_comb
            begin
                clr = 16'h0000;
                if (flag_wr && wr_group == 3'(gi))
                begin
                    clr = wr_data_reg;
                end
                if (rollup_wr)
                begin
                    clr = clr | {{8{wr_data_reg[8 + gi]}}, {8{wr_data_reg[gi]}}};
                end
            end
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    flag_reg[gi] <= ROLLUP_RESET;
                end
                else
                begin
                    // a fresh event outranks a clear in the same cycle
                    flag_reg[gi] <= (flag_reg[gi] & ~clr) | alert_set[gi];
                end
            end
        end
    endgenerate

    logic [15:0] rollup;
    logic [15:0] clamp_word;
    always_comb
    begin
        rollup = 16'h0000;
        for (int g = 0; g < NUM_FLAG_GROUPS; g++)
        begin
            rollup[8 + g] = |flag_reg[g][15:8];
            rollup[g] = |flag_reg[g][7:0];
        end
    end
    // clamp flags sit as high alerts, supply alarms both as low alerts, positive at bit 4, negative at bit 0
    assign clamp_word = {4'h0, loop_status.clamp_active, 3'h0, loop_status.pos_supply_alarm,
        3'h0, loop_status.neg_supply_alarm};

    // ==========================================
    // routing masks and the alert pin
    generate
        for (gi = 0; gi < NUM_ROUTE_GROUPS; gi++)
        begin : g_route
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    route_reg[gi] <= ROUTE_RESET;
                end
                else if (wr_hit && page_reg == PAGE_ROUTE0 && wr_group == 3'(gi))
                begin
                    route_reg[gi] <= wr_data_reg;
                end
            end
        end
    endgenerate

    logic routed;
    always_comb
    begin
        routed = |(clamp_word & route_reg[5]);
        for (int g = 0; g < NUM_FLAG_GROUPS; g++)
        begin
            routed = routed | (|(flag_reg[g] & route_reg[g]));
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            first_alert_output <= 1'b0;
        end
        else
        begin
            first_alert_output <= routed;
        end
    end

    // ==========================================
    // read data, left aligned for byte registers
    logic [15:0] rd_word;
    always_comb
    begin
        logic [4:0] ch;
        logic [2:0] grp;
        ch = chan_of(page_reg, rx_addr);
        grp = group_of(rx_addr);
        rd_word = 16'h0000;
        if (rx_addr == ADDR_PAGE_SEL)
        begin
            rd_word = {page_reg, 8'h00};
        end
        else
        begin
            case (page_reg)
                PAGE_PEAK0, PAGE_PEAK1:
                    rd_word = (ch < CH_UNI_TRIM0) ? peak_reg[ch] : 16'h0000;
                PAGE_TRIM0, PAGE_TRIM1:
                    rd_word = (ch != CH_NONE) ? {trim_out[ch], 8'h00} : 16'h0000;
                PAGE_ALERT:
                    if (rx_addr == ADDR_ROLLUP)
                        rd_word = rollup;
                    else if (grp < 3'd5)
                        rd_word = flag_reg[grp];
                    else if (grp == 3'd5)
                        rd_word = clamp_word;
                PAGE_ROUTE0:
                    rd_word = (grp < 3'd6) ? route_reg[grp] : 16'h0000;
                default:
                    rd_word = 16'h0000;
            endcase
        end
    end

    // ==========================================
    // serial output: loaded after the address byte, shifted on falling sclk
    logic [15:0] tx_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_reg <= 16'h0000;
            spi_dout <= 1'b0;
            spi_dout_oe <= 1'b0;
        end
        else
        begin
            spi_dout_oe <= !cs_s2_reg && !addr_phase_reg && read_reg;
            if (sclk_rise && addr_phase_reg && bit_cnt_reg == 4'd7 && rx_reg[6])
            begin
                tx_reg <= rd_word;
            end
            else if (sclk_fall && !addr_phase_reg && read_reg)
            begin
                spi_dout <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
        end
    end

endmodule
`default_nettype wire

// [poab_bank_props.sv]
// checker: port-level properties of the peak, trim and alert register bank
`default_nettype none
module poab_bank_props
    import poab_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_din,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    input wire poab_pkg::poab_conv_s conv,
    input wire poab_pkg::poab_flags_t alert_set,
    input wire poab_pkg::poab_loop_s loop_status,
    input wire logic copy_enable,
    input wire poab_pkg::poab_trims_t trim_out,
    input wire logic [3:0] bipolar_trim_update,
    input wire logic first_alert_output
);
    // ==========
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // writes land while the frame is open, so a rise after a quiet bus has a source
    sequence s_cs_idle;
        spi_cs_n [*6];
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0) $fell(sys_rst) |->
        trim_out == '0 && !first_alert_output && bipolar_trim_update == 4'h0 && !spi_dout_oe)
        else $error("outputs not cleared by reset");
    a_pulse_single: assert property (bipolar_trim_update != 4'h0 |=>
        bipolar_trim_update == 4'h0)
        else $error("trim update pulse too long");
    a_bi_trim_link: assert property ($changed(trim_out[27]) |->
        bipolar_trim_update[0] || $past(bipolar_trim_update[0]))
        else $error("bipolar trim changed without update pulse");
    a_copy_uni: assert property ($changed(trim_out[26:23]) && $past(copy_enable, 2) |->
        trim_out[23] == trim_out[24] && trim_out[24] == trim_out[25]
        && trim_out[25] == trim_out[26])
        else $error("unipolar trims differ under copy");
    a_copy_bi: assert property ($changed(trim_out[30:27]) && $past(copy_enable, 2) |->
        trim_out[27] == trim_out[28] && trim_out[28] == trim_out[29]
        && trim_out[29] == trim_out[30])
        else $error("bipolar trims differ under copy");
    a_alert_cause: assert property (s_cs_idle ##1 $rose(first_alert_output) |->
        $past(|alert_set, 2) || $past(|loop_status) || $past(|loop_status, 2))
        else $error("alert output rose without a cause");
    a_oe_cs_off: assert property (spi_cs_n [*5] |-> !spi_dout_oe)
        else $error("data out driven while deselected");
    a_pulse_in_frame: assert property (bipolar_trim_update != 4'h0 |->
        !$past(spi_cs_n, 2))
        else $error("trim update outside a frame");
    a_trims_idle: assert property (spi_cs_n [*8] |-> $stable(trim_out))
        else $error("trims changed with bus idle");

    c_copy: cover property (copy_enable && bipolar_trim_update == 4'hf);
    c_alert: cover property ($rose(first_alert_output));
    c_read: cover property ($rose(spi_dout_oe));
endmodule

bind poab_bank poab_bank_props poab_bank_props_i (
    .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .conv(conv),
    .alert_set(alert_set), .loop_status(loop_status), .copy_enable(copy_enable),
    .trim_out(trim_out), .bipolar_trim_update(bipolar_trim_update),
    .first_alert_output(first_alert_output)
);
`default_nettype wire

// [poab_host.sv]
// host model: serial bus master framing register reads and writes
`default_nettype none
module poab_host (
    input wire logic clk,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_din
);
    timeunit 1ns;
    timeprecision 1ns;
    // each sclk level spans 6 clk, above the 3 the pin synchronisers need
    localparam int HALF = 6;
    wire logic miso = spi_dout_oe ? spi_dout : 1'bz;

    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_din = 1'b0;
    end

    // ==========
    // framing
    task automatic send_bit(input logic b, output logic got);
        spi_din <= b;
        repeat (HALF) @(posedge clk);
        got = miso;
        spi_sclk <= ~spi_sclk;
        repeat (HALF) @(posedge clk);
        spi_sclk <= ~spi_sclk;
    endtask

    task automatic xfer(input logic [7:0] addr, input logic [15:0] wd, input int nb,
                        output logic [15:0] rd);
        logic g;
        rd = 16'h0000;
        spi_cs_n <= ~spi_cs_n;
        repeat (HALF) @(posedge clk);
        for (int i = 7; i >= 0; i--) send_bit(addr[i], g);
        for (int i = nb * 8 - 1; i >= 0; i--)
        begin
            send_bit(wd[i], g);
            rd = {rd[14:0], g};
        end
        repeat (HALF) @(posedge clk);
        spi_cs_n <= ~spi_cs_n;
        spi_din <= ~spi_din;
        repeat (HALF) @(posedge clk);
    endtask

    task automatic select_page(input logic [7:0] p);
        logic [15:0] r;
        xfer(8'h00, {8'h00, p}, 1, r); // one select serves the whole page
    endtask
endmodule
`default_nettype wire

// [poab_bank_tb.sv]
// testbench: drives the register bank through the host model and checks results
`default_nettype none
module poab_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import poab_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic copy_enable = 1'b0;
    logic spi_cs_n, spi_sclk, spi_din, spi_dout, spi_dout_oe, first_alert_output;
    poab_conv_s conv = '0;
    poab_flags_t alert_set = '0;
    poab_loop_s loop_status = '0;
    poab_trims_t trim_out;
    poab_flags_t fl;
    logic [3:0] bipolar_trim_update;
    logic [15:0] lfsr_reg = 16'd8390;
    logic [15:0] rd, c;
    logic [15:0] peak_exp [4];
    logic [7:0] tp [4] = '{8'h0e, 8'h0e, 8'h0f, 8'h0f};
    logic [5:0] ta [4] = '{6'h10, 6'h22, 6'h13, 6'h2b};
    int ti [4] = '{0, 6, 14, 22};
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;

    poab_bank poab_bank_i (.clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout),
        .spi_dout_oe(spi_dout_oe), .conv(conv), .alert_set(alert_set),
        .loop_status(loop_status), .copy_enable(copy_enable), .trim_out(trim_out),
        .bipolar_trim_update(bipolar_trim_update), .first_alert_output(first_alert_output));
    poab_host poab_host_i (.clk(clk), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_din(spi_din));

    always #10 clk = ~clk;

    // ==========
    // helpers
    function automatic logic [15:0] rnd();
        lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        return lfsr_reg;
    endfunction

    function automatic logic [15:0] rollup_of(input poab_flags_t f);
        logic [15:0] r;
        r = 16'h0000;
        for (int g = 0; g < 5; g++)
        begin
            r[8 + g] = |f[g][15:8];
            r[g] = |f[g][7:0];
        end
        return r;
    endfunction

    task automatic test_done();
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] want);
        check_count++;
        if (got !== want)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d, input int nb);
        poab_host_i.xfer({2'b00, a}, d, nb, rd);
    endtask

    task automatic rdc(input logic [5:0] a, input int nb, input logic [15:0] want);
        poab_host_i.xfer({2'b10, a}, 16'h0000, nb, rd);
        check(rd, want);
    endtask

    task automatic pulse_conv(input logic [4:0] ch, input logic [15:0] code);
        @(posedge clk);
        conv <= '{valid: 1'b1, chan: ch, code: code};
        @(posedge clk);
        conv <= '0;
    endtask

    task automatic pulse_alert(input poab_flags_t f);
        @(posedge clk);
        alert_set <= f;
        @(posedge clk);
        alert_set <= '0;
        repeat (3) @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            test_done();
        end
    end

    // ==========
    // scenarios
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        poab_host_i.select_page(8'h10);
        rdc(6'h10, 2, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            poab_host_i.select_page(tp[k]);
            c = rnd();
            wr(ta[k], c, 1);
            rdc(ta[k], 1, {8'h00, c[7:0]});
            check({8'h00, trim_out[ti[k]]}, {8'h00, c[7:0]});
        end
        rdc(6'h3e, 1, 16'h0000);
        poab_host_i.select_page(8'h0e);
        copy_enable <= 1'b1;
        c = rnd();
        wr(6'h32, c, 1);
        for (int k = 23; k < 27; k++) check({8'h00, trim_out[k]}, {8'h00, c[7:0]});
        wr(6'h35, ~c, 1);
        for (int k = 27; k < 31; k++) check({8'h00, trim_out[k]}, {8'h00, ~c[7:0]});
        copy_enable <= 1'b0;
        wr(6'h37, c, 1);
        check({trim_out[30], trim_out[29]}, {c[7:0], ~c[7:0]});
        poab_host_i.select_page(8'h0c);
        peak_exp = '{default: 16'h0000};
        for (int k = 0; k < 12; k++)
        begin
            c = rnd();
            pulse_conv(5'(k % 4), c);
            if (c > peak_exp[k % 4]) peak_exp[k % 4] = c;
        end
        for (int k = 0; k < 4; k++) rdc(6'h10 + 6'(k), 2, peak_exp[k]);
        wr(6'h12, 16'hffff, 2);
        rdc(6'h12, 2, 16'h0000);
        c = rnd();
        pulse_conv(5'd9, c);
        rdc(6'h2a, 2, c);
        poab_host_i.select_page(8'h0d);
        pulse_conv(5'd16, c);
        pulse_conv(5'd19, c);
        rdc(6'h15, 2, c);
        rdc(6'h28, 2, 16'((32'(c) * 32'(SHUNT_DIV50_MUL)) >> 16));
        poab_host_i.select_page(8'h10);
        fl = '0;
        fl[0] = 16'h0200;
        fl[3] = 16'h0004;
        fl[4] = 16'h0101;
        pulse_alert(fl);
        rdc(6'h10, 2, rollup_of(fl));
        rdc(6'h12, 2, 16'h0200);
        poab_host_i.select_page(8'h11);
        rdc(6'h12, 2, 16'h0000);
        check({15'h0, first_alert_output}, 16'h0000);
        wr(6'h12, 16'h0200, 2);
        wr(6'h19, 16'h0001, 2);
        check({15'h0, first_alert_output}, 16'h0001);
        poab_host_i.select_page(8'h10);
        wr(6'h12, 16'h0200, 2);
        rdc(6'h12, 2, 16'h0000);
        check({15'h0, first_alert_output}, 16'h0001);
        wr(6'h19, 16'h0001, 2);
        check({15'h0, first_alert_output}, 16'h0000);
        rdc(6'h19, 2, 16'h0100);
        wr(6'h10, 16'h1008, 2);
        rdc(6'h18, 2, 16'h0000);
        rdc(6'h10, 2, 16'h0000);
        pulse_alert(fl);
        check({15'h0, first_alert_output}, 16'h0001);
        wr(6'h10, 16'h1119, 2);
        check({15'h0, first_alert_output}, 16'h0000);
        c = rnd();
        loop_status <= {1'b0, 1'b1, c[3:0]};
        wr(6'h1a, 16'hffff, 2);
        rdc(6'h1a, 2, {4'h0, c[3:0], 8'h10});
        poab_host_i.select_page(8'h11);
        wr(6'h1a, 16'h0010, 2);
        check({15'h0, first_alert_output}, 16'h0001);
        test_done();
    end
endmodule
`default_nettype wire
